// ===== ocl_map.svh
`ifndef OCL_MAP_SVH
`define OCL_MAP_SVH

// Readback port selects
`define OCL_PORT_TALLY 5'h0e
`define OCL_PORT_INDEX 5'h04

// Mode control and clock-enable field positions
`define OCL_MODE_DUAL_BIT 7
`define OCL_MODE_LOAD_N_BIT 6
`define OCL_CLKEN_N_BIT 0

// Reset values
`define OCL_TALLY_RESET 12'h000
`define OCL_INDEX_RESET 4'h0
`define OCL_DUAL_RESET 1'b0
`define OCL_LOAD_N_RESET 1'b1
`define OCL_CLKEN_N_RESET 1'b1
`define OCL_STROBE_IDLE 7'h7f

// Counter and memory shape
`define OCL_TALLY_LAST 12'hfff
`define OCL_SLICES 3
`define OCL_DEPTH 16
`define OCL_SYNC_WIDTH 21

// Strobe positions inside the synchronised vector
`define OCL_S_INDEX 0
`define OCL_S_LOW 1
`define OCL_S_HIGH 2
`define OCL_S_PRESET 3
`define OCL_S_STEP 4
`define OCL_S_MODE 5
`define OCL_S_CLKEN 6
`define OCL_S_READ 7

`endif

// ===== ocl_pkg.sv
package ocl_pkg;
  typedef logic [11:0] ocl_word_type;
  typedef logic [3:0] ocl_index_type;
  typedef logic [7:0] ocl_byte_type;
  typedef logic [4:0] ocl_port_type;
  typedef logic [3:0] ocl_nibble_type;
endpackage

// ===== ocl_sync.sv
`timescale 1ns/1ns
`default_nettype none
module ocl_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] async_in,
  output var logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync_out;

  always_comb begin
    next_stage1 = async_in;
    next_sync_out = stage1;
  end

  // Idle level of every pin is high
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= '1;
      sync_out <= '1;
    end else begin
      stage1 <= next_stage1;
      sync_out <= next_sync_out;
    end
  end
endmodule
`default_nettype wire

// ===== ocl_tally.sv
// Notes on behaviour
// R1 - 12-bit up-counter, parallel-loaded from RAM
// R2 - RAM is 16 words, three 4-bit slices
// R3 - Index strobe in load mode captures address
// R4 - Low write strobe stores low byte
// R5 - High write strobe stores top nibble
// R6 - RAM outputs inverse of written data
// R7 - Preset strobe loads addressed word into counter
// R8 - Each step strobe advances counter once
// R9 - Carries ripple across all three slices
// R10 - Bits 1, 6, 11 readable at 4..2
// R11 - Readback driven only when port 0E or 04 selected
// R12 - Mode write sets qualifier and load mode
// R13 - Clock-enable write enables index clocking
// R14 - Host verifies loading word by word
// R15 - Host stops counting check on mismatch
// R16 - Host presets zero by writing FF
// R17 - Port 04 shows index, port 0E tally
// R18 - Count completion reloads from next word
// R19 - Strobes synchronised, each acts exactly once
`timescale 1ns/1ns
`default_nettype none
`include "ocl_map.svh"
module ocl_tally (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire ocl_pkg::ocl_byte_type host_data,
  input wire ocl_pkg::ocl_port_type host_addr,
  input wire logic level_index_strobe_n,
  input wire logic tally_ram_low_write_n,
  input wire logic tally_ram_high_write_n,
  input wire logic tally_preset_strobe_n,
  input wire logic tally_step_strobe_n,
  input wire logic mode_control_write_n,
  input wire logic clock_enable_write_n,
  input wire logic tally_readback_enable_n,
  output var ocl_pkg::ocl_byte_type host_read_data,
  output var logic host_read_oe,
  output var logic paired_qualifier_select,
  output var logic level_index_load_mode_n,
  output var logic stack_clock_enable_n,
  output var ocl_pkg::ocl_word_type event_tally,
  output var ocl_pkg::ocl_index_type level_index
);
  import ocl_pkg::*;

  logic [`OCL_SYNC_WIDTH-1:0] raw_in;
  logic [`OCL_SYNC_WIDTH-1:0] synced;
  logic [7:0] strobe_n;
  logic [6:0] prev_strobe_n;
  logic [6:0] next_prev_strobe_n;
  logic [6:0] fire;
  ocl_byte_type data;
  ocl_port_type addr;
  logic read_sel;
  ocl_word_type ram [`OCL_DEPTH];
  ocl_word_type next_ram [`OCL_DEPTH];
  logic [`OCL_SLICES-1:0] slice_we;
  ocl_nibble_type slice_data [`OCL_SLICES];
  ocl_index_type reload_index;
  logic wrap;
  ocl_word_type next_tally;
  ocl_index_type next_index;
  logic next_dual;
  logic next_load_n;
  logic next_clken_n;
  ocl_byte_type next_read_data;
  logic next_read_oe;

  // One bit per slice lands at byte bits 4..2, low slice on top
  function automatic ocl_byte_type visible_byte(input ocl_word_type w);
    visible_byte = {3'h0, w[1], w[6], w[11], 2'h0}; // R10
  endfunction

  assign raw_in = {host_addr, host_data, tally_readback_enable_n, clock_enable_write_n,
                   mode_control_write_n, tally_step_strobe_n, tally_preset_strobe_n,
                   tally_ram_high_write_n, tally_ram_low_write_n, level_index_strobe_n};

  ocl_sync #(.WIDTH(`OCL_SYNC_WIDTH)) u_sync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .async_in(raw_in),
    .sync_out(synced)
  );

  assign strobe_n = synced[7:0];
  assign data = synced[15:8];
  assign addr = synced[20:16];
  assign read_sel = !strobe_n[`OCL_S_READ];
  assign fire = prev_strobe_n & ~strobe_n[6:0]; // R19

  // Slice write enables and data
  genvar s;
  generate
    for (s = 0; s < `OCL_SLICES; s++) begin : g_slice
      if (s < 2) begin : g_low
        assign slice_we[s] = fire[`OCL_S_LOW]; // R4
        assign slice_data[s] = ~data[s*4 +: 4]; // R6
      end else begin : g_high
        assign slice_we[s] = fire[`OCL_S_HIGH]; // R5
        assign slice_data[s] = ~data[3:0]; // R6
      end
    end
  endgenerate

  always_comb begin
    next_ram = ram;
    for (int k = 0; k < `OCL_SLICES; k++) begin
      if (slice_we[k]) begin
        next_ram[level_index][k*4 +: 4] = slice_data[k]; // R2
      end
    end
  end

  always_comb begin
    next_prev_strobe_n = strobe_n[6:0];
    reload_index = 4'(level_index + 4'h1);
    wrap = fire[`OCL_S_STEP] && !fire[`OCL_S_PRESET] && (event_tally == `OCL_TALLY_LAST);
    next_tally = event_tally;
    next_index = level_index;
    next_dual = paired_qualifier_select;
    next_load_n = level_index_load_mode_n;
    next_clken_n = stack_clock_enable_n;
    if (fire[`OCL_S_PRESET]) begin
      next_tally = ram[level_index]; // R7
    end else if (wrap) begin
      next_tally = ram[reload_index]; // R18
    end else if (fire[`OCL_S_STEP]) begin
      next_tally = 12'(event_tally + 12'h001); // R8 R9 R1
    end
    if (fire[`OCL_S_INDEX] && !stack_clock_enable_n) begin
      if (!level_index_load_mode_n) begin
        next_index = data[3:0]; // R3
      end else begin
        next_index = reload_index;
      end
    end else if (wrap && !stack_clock_enable_n && level_index_load_mode_n) begin
      next_index = reload_index; // R18
    end
    if (fire[`OCL_S_MODE]) begin
      next_dual = data[`OCL_MODE_DUAL_BIT]; // R12
      next_load_n = data[`OCL_MODE_LOAD_N_BIT]; // R12
    end
    if (fire[`OCL_S_CLKEN]) begin
      next_clken_n = data[`OCL_CLKEN_N_BIT]; // R13
    end
    next_read_oe = read_sel && (addr == `OCL_PORT_TALLY || addr == `OCL_PORT_INDEX); // R11
    if (addr == `OCL_PORT_INDEX) begin
      next_read_data = {2'h0, level_index, 2'h0}; // R17
    end else begin
      next_read_data = visible_byte(event_tally); // R17
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int k = 0; k < `OCL_DEPTH; k++) begin
        ram[k] <= `OCL_TALLY_RESET;
      end
    end else begin
      ram <= next_ram;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_strobe_n <= `OCL_STROBE_IDLE;
      event_tally <= `OCL_TALLY_RESET;
      level_index <= `OCL_INDEX_RESET;
      paired_qualifier_select <= `OCL_DUAL_RESET;
      level_index_load_mode_n <= `OCL_LOAD_N_RESET;
      stack_clock_enable_n <= `OCL_CLKEN_N_RESET;
      host_read_data <= 8'h00;
      host_read_oe <= 1'b0;
    end else begin
      prev_strobe_n <= next_prev_strobe_n;
      event_tally <= next_tally;
      level_index <= next_index;
      paired_qualifier_select <= next_dual;
      level_index_load_mode_n <= next_load_n;
      stack_clock_enable_n <= next_clken_n;
      host_read_data <= next_read_data;
      host_read_oe <= next_read_oe;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence s_step_no_preset;
    fire[`OCL_S_STEP] && !fire[`OCL_S_PRESET];
  endsequence

  sequence s_wrap_step;
    s_step_no_preset ##0 (event_tally == `OCL_TALLY_LAST);
  endsequence

  chk_preset_load: assert property ( // R7
    fire[`OCL_S_PRESET] |=> event_tally == $past(ram[level_index]))
    else $error("preset did not load addressed word");
  chk_step_once: assert property ( // R8
    s_step_no_preset ##0 (event_tally != `OCL_TALLY_LAST) |=>
      event_tally == 12'($past(event_tally) + 12'h001))
    else $error("step did not advance tally by one");
  chk_carry_chain: assert property ( // R9
    s_step_no_preset ##0 (event_tally == 12'h7ff) |=> event_tally == 12'h800)
    else $error("carry did not reach top slice");
  chk_wrap_reload: assert property ( // R18
    s_wrap_step |=> event_tally == $past(ram[reload_index]))
    else $error("completion did not reload next word");
  chk_index_load: assert property ( // R3
    fire[`OCL_S_INDEX] && !stack_clock_enable_n && !level_index_load_mode_n
      |=> level_index == $past(data[3:0]))
    else $error("index not captured in load mode");
  chk_ram_low: assert property ( // R4
    fire[`OCL_S_LOW] |=> ram[$past(level_index)][7:0] == ~$past(data))
    else $error("low byte not stored inverted");
  chk_ram_high: assert property ( // R5
    fire[`OCL_S_HIGH] |=> ram[$past(level_index)][11:8] == ~$past(data[3:0]))
    else $error("high nibble not stored inverted");
  chk_mode_decode: assert property ( // R12
    fire[`OCL_S_MODE] && data == 8'h80 |=>
      paired_qualifier_select && !level_index_load_mode_n)
    else $error("mode write 80 misdecoded");
  chk_clock_enable: assert property ( // R13
    fire[`OCL_S_CLKEN] && data == 8'h00 |=> !stack_clock_enable_n)
    else $error("clock enable write 00 misdecoded");
  chk_read_gate: assert property ( // R11
    !read_sel |=> !host_read_oe)
    else $error("readback driven while not selected");
  chk_bit_order: assert property ( // R10
    read_sel && addr == `OCL_PORT_TALLY |=>
      host_read_oe && host_read_data == visible_byte($past(event_tally)))
    else $error("tally readback bits misplaced");
  chk_strobe_once: assert property ( // R19
    !fire[`OCL_S_STEP] && !fire[`OCL_S_PRESET] |=> event_tally == $past(event_tally))
    else $error("tally moved without a new strobe");
endmodule
`default_nettype wire

// ===== ocl_host_model.sv
`timescale 1ns/1ns
`default_nettype none
`include "ocl_map.svh"
module ocl_host_model (
  input wire logic core_clk,
  input wire ocl_pkg::ocl_byte_type host_read_data,
  input wire logic host_read_oe,
  output var ocl_pkg::ocl_byte_type host_data,
  output var ocl_pkg::ocl_port_type host_addr,
  output wire logic level_index_strobe_n,
  output wire logic tally_ram_low_write_n,
  output wire logic tally_ram_high_write_n,
  output wire logic tally_preset_strobe_n,
  output wire logic tally_step_strobe_n,
  output wire logic mode_control_write_n,
  output wire logic clock_enable_write_n,
  output var logic tally_readback_enable_n
);
  import ocl_pkg::*;
  logic [6:0] strobe_n;
  initial begin
    strobe_n = `OCL_STROBE_IDLE;
    host_data = 8'h00;
    host_addr = 5'h00;
    tally_readback_enable_n = 1'b1;
  end
  assign level_index_strobe_n = strobe_n[`OCL_S_INDEX];
  assign tally_ram_low_write_n = strobe_n[`OCL_S_LOW];
  assign tally_ram_high_write_n = strobe_n[`OCL_S_HIGH];
  assign tally_preset_strobe_n = strobe_n[`OCL_S_PRESET];
  assign tally_step_strobe_n = strobe_n[`OCL_S_STEP];
  assign mode_control_write_n = strobe_n[`OCL_S_MODE];
  assign clock_enable_write_n = strobe_n[`OCL_S_CLKEN];
  // Data set a cycle early, held past strobe release
  task automatic put(input int sel, input ocl_byte_type data, input int width);
    @(posedge core_clk) #1;
    host_data = data;
    @(posedge core_clk) #1;
    strobe_n[sel] = 1'b0;
    repeat (width) @(posedge core_clk);
    #1 strobe_n[sel] = 1'b1;
    repeat (2) @(posedge core_clk);
    #1 host_data = ~data;
  endtask
  // Readback sampled once sync and register settle
  task automatic look(input ocl_port_type addr, output ocl_byte_type data, output logic oe);
    @(posedge core_clk) #1;
    host_addr = addr;
    tally_readback_enable_n = 1'b0;
    repeat (4) @(posedge core_clk);
    #1 data = host_read_data;
    oe = host_read_oe;
    tally_readback_enable_n = 1'b1;
    host_addr = ~addr;
    repeat (3) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// ===== ocl_tally_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "ocl_map.svh"
module ocl_tally_test;
  import ocl_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  ocl_byte_type host_data, host_read_data, rd_data;
  ocl_port_type host_addr;
  ocl_word_type event_tally;
  ocl_index_type level_index;
  logic idx_n, low_n, high_n, pre_n, step_n, mode_n, clken_n, rden_n;
  logic host_read_oe, paired, load_n, sclk_n, rd_oe;
  int miscompares = 0;
  int samples_checked = 0;
  int i;
  ocl_word_type words [16] = '{12'h515, 12'haa8, 12'h555, 12'hae8, 12'h517, 12'haaa,
    12'h557, 12'haea, 12'h515, 12'haa8, 12'h555, 12'hae8, 12'h517, 12'haaa, 12'h557, 12'haea};
  always #5 core_clk = ~core_clk;
  ocl_host_model host_u (.core_clk(core_clk), .host_read_data(host_read_data),
    .host_read_oe(host_read_oe), .host_data(host_data), .host_addr(host_addr),
    .level_index_strobe_n(idx_n), .tally_ram_low_write_n(low_n),
    .tally_ram_high_write_n(high_n), .tally_preset_strobe_n(pre_n),
    .tally_step_strobe_n(step_n), .mode_control_write_n(mode_n),
    .clock_enable_write_n(clken_n), .tally_readback_enable_n(rden_n));
  ocl_tally dut_u (.core_clk(core_clk), .arst_n(arst_n), .host_data(host_data),
    .host_addr(host_addr), .level_index_strobe_n(idx_n), .tally_ram_low_write_n(low_n),
    .tally_ram_high_write_n(high_n), .tally_preset_strobe_n(pre_n),
    .tally_step_strobe_n(step_n), .mode_control_write_n(mode_n),
    .clock_enable_write_n(clken_n), .tally_readback_enable_n(rden_n),
    .host_read_data(host_read_data), .host_read_oe(host_read_oe),
    .paired_qualifier_select(paired), .level_index_load_mode_n(load_n),
    .stack_clock_enable_n(sclk_n), .event_tally(event_tally), .level_index(level_index));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic rd_chk(input ocl_port_type a, input ocl_byte_type e, input logic e_oe);
    host_u.look(a, rd_data, rd_oe);
    chk(rd_oe, e_oe, "read enable");
    if (e_oe) chk(rd_data, e, "read data");
  endtask
  task automatic put(input int sel, input ocl_byte_type d);
    host_u.put(sel, d, 2);
  endtask
  task automatic finish_test;
    $display("checked %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #400000;
    miscompares++;
    finish_test;
  end
  initial begin
    repeat (3) @(posedge core_clk);
    #1 arst_n = 1'b1;
    chk({event_tally, level_index, paired, load_n, sclk_n, host_read_oe}, 20'h00006, "reset");
    put(`OCL_S_MODE, 8'h80);
    chk({paired, load_n}, 2'b10, "mode");
    put(`OCL_S_INDEX, 8'h05);
    chk(level_index, 4'h0, "index while disabled");
    put(`OCL_S_CLKEN, 8'h00);
    chk(sclk_n, 1'b0, "clock enable");
    $display("test mode done");
    for (i = 0; i < 16; i++) begin
      put(`OCL_S_INDEX, i[7:0]);
      put(`OCL_S_LOW, ~words[i][7:0]);
      put(`OCL_S_HIGH, {4'ha, ~words[i][11:8]});
    end
    for (i = 0; i < 16; i++) begin
      put(`OCL_S_INDEX, i[7:0]);
      chk(level_index, i[3:0], "index");
      put(`OCL_S_PRESET, 8'h00);
      chk(event_tally, words[i], "preset");
      rd_chk(`OCL_PORT_TALLY, {3'b000, i[2:0], 2'b00}, 1'b1);
      rd_chk(`OCL_PORT_INDEX, {2'b00, i[3:0], 2'b00}, 1'b1);
      if (miscompares != 0) break;
    end
    rd_chk(5'h05, 8'h00, 1'b0);
    $display("test load done");
    put(`OCL_S_INDEX, 8'h00);
    put(`OCL_S_LOW, 8'hff);
    put(`OCL_S_HIGH, 8'hff);
    put(`OCL_S_PRESET, 8'h00);
    chk(event_tally, 12'h000, "zero preset");
    host_u.put(`OCL_S_STEP, 8'h00, 8);
    chk(event_tally, 12'h001, "long step");
    put(`OCL_S_STEP, 8'h00);
    chk(event_tally, 12'h002, "two steps");
    rd_chk(`OCL_PORT_TALLY, 8'h10, 1'b1);
    if (miscompares == 0) repeat (62) put(`OCL_S_STEP, 8'h00);
    chk(event_tally, 12'h040, "count 040");
    rd_chk(`OCL_PORT_TALLY, 8'h08, 1'b1);
    if (miscompares == 0) repeat (1984) put(`OCL_S_STEP, 8'h00);
    chk(event_tally, 12'h800, "count 800");
    rd_chk(`OCL_PORT_TALLY, 8'h04, 1'b1);
    $display("test count done");
    put(`OCL_S_LOW, 8'h00);
    put(`OCL_S_HIGH, 8'h00);
    put(`OCL_S_INDEX, 8'h01);
    put(`OCL_S_LOW, 8'hbf);
    put(`OCL_S_HIGH, 8'hff);
    put(`OCL_S_INDEX, 8'h00);
    put(`OCL_S_PRESET, 8'h00);
    chk(event_tally, 12'hfff, "full preset");
    put(`OCL_S_MODE, 8'hf0);
    chk(load_n, 1'b1, "count mode");
    put(`OCL_S_STEP, 8'h00);
    chk({event_tally, level_index}, 16'h0401, "reload");
    rd_chk(`OCL_PORT_INDEX, 8'h04, 1'b1);
    rd_chk(`OCL_PORT_TALLY, 8'h08, 1'b1);
    put(`OCL_S_INDEX, 8'h00);
    chk(level_index, 4'h2, "index count");
    $display("test reload done");
    finish_test;
  end
endmodule
`default_nettype wire
